// *** rtl/spc_config_decode.sv ***
/*
 Segment protection configuration decoder: after reset release, reads the four
 configuration words from configuration space one per cycle, holds them,
 and drives decoded protection and debug start-up controls until the next
 reset. Assumes a configuration memory with one-cycle read latency, and
 RAM limit bits that are stable from reset release onward.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
// Overview of operation
// [R1] Boot RAM field bits 13-12: 11 none, 10 small, 01 medium, 00 large.
// [R2] Boot EEPROM bit 8: 1 no segment, 0 protects 256 bytes.
// [R3] EEPROM partition follows boot EEPROM bit and secure EEPROM field jointly. Code decodes each one separately instead.
// [R4] Boot flash bits 3-1: x11 none, low bits size, top bit security.
// [R5] Boot write-protect bit 0: 1 allows writes, 0 blocks them.
// [R6] Unimplemented bits of boot, secure and general words read zero.
// [R7] Secure RAM size from secure field, boot field and two limit bits. Code outputs these inputs instead of a size.
// [R8] Secure EEPROM: 11 none, 00 is 2048 bytes, other codes reserved.
// [R9] Secure flash bits 3-1 decode like the boot flash field.
// [R10] Secure write-protect bit 0: 1 allows writes, 0 blocks them.
// [R11] Advanced general field bits 2-1: 11 none, 10 standard, 0x high.
// [R12] General write-protect bit 0 gates writes in both variants.
// [R13] Basic general bit 1: 1 unprotected, 0 code protected.
// [R14] Debug word bit 7: 1 resets to user mode, 0 debug mode.
// [R15] Debug word bit 6: 1 operational mode, 0 clip-on emulation.
// [R16] Channel bits 1-0: 11 shared pair, 10 one, 01 two, 00 three.
// [R17] Programmed bits read zero, unprogrammed bits read one.
// [R18] Words load during reset; outputs hold until next reset. Code loads just after reset release instead.
module spc_config_decode
    import spc_pkg::*;
#(
    parameter bit ADVANCED = 1'b1
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Configuration space read port
    output logic cfg_rd_en,
    output logic [2:0] cfg_rd_idx,
    input wire logic [23:0] cfg_rd_data,
    // RAM segment limit bits from the RAM control registers
    input wire logic boot_ram_limit_bit,
    input wire logic secure_ram_limit_bit,
    // Software read-back of held words
    input wire logic [2:0] sw_rd_idx,
    output logic [23:0] sw_rd_data,
    // Decoded outputs
    output logic config_valid,
    output spc_prot_s prot,
    output spc_debug_s dbg
);
    // Whole module state
    typedef struct packed {
        spc_state_e state;
        logic [2:0] idx;
        logic [2:0] got_idx;
        logic pending;
        logic [23:0] boot_word;
        logic [23:0] secure_word;
        logic [23:0] general_word;
        logic [23:0] debug_word;
        logic ram_limit_boot;
        logic ram_limit_secure;
        logic valid;
        logic [23:0] rd_data;
    } spc_state_s;

    spc_state_s cur;
    spc_state_s next_cur;
    logic [23:0] gen_mask;
    spc_flash_s boot_seg;
    spc_flash_s secure_seg;
    spc_debug_s dbg_dec;

    assign gen_mask = ADVANCED ? `SPC_MASK_GEN_ADV : `SPC_MASK_GEN_BASIC;

    // Loader walks indices 3..6 in the cycles just after reset release
    always_comb begin
        next_cur = cur;
        next_cur.pending = 1'b0;
        case (cur.state)
            spc_st_load: begin
                next_cur.pending = 1'b1;
                next_cur.got_idx = cur.idx;
                if (cur.idx == `SPC_IDX_DEBUG) begin
                    next_cur.state = spc_st_wait;
                end else begin
                    next_cur.idx = cur.idx + 3'h1;
                end
            end
            spc_st_wait: begin
                // Latch limit bits once words are in; they stay fixed afterwards
                next_cur.state = spc_st_run;
                next_cur.valid = 1'b1;
                next_cur.ram_limit_boot = boot_ram_limit_bit; // see [R7]
                next_cur.ram_limit_secure = secure_ram_limit_bit;
            end
            spc_st_run: next_cur.state = spc_st_run; // see [R18]
            default: next_cur.state = spc_st_load;
        endcase
        // Store returned word with unimplemented bits forced; see [R6]
        if (cur.pending) begin
            case (cur.got_idx)
                `SPC_IDX_BOOT: next_cur.boot_word = cfg_rd_data & `SPC_MASK_BOOT;
                `SPC_IDX_SECURE: next_cur.secure_word = cfg_rd_data & `SPC_MASK_SECURE;
                `SPC_IDX_GENERAL: next_cur.general_word = cfg_rd_data & gen_mask;
                default: next_cur.debug_word = cfg_rd_data | `SPC_FILL_DEBUG;
            endcase
        end
        // Registered software read-back
        case (sw_rd_idx)
            `SPC_IDX_BOOT: next_cur.rd_data = cur.boot_word;
            `SPC_IDX_SECURE: next_cur.rd_data = cur.secure_word;
            `SPC_IDX_GENERAL: next_cur.rd_data = cur.general_word;
            `SPC_IDX_DEBUG: next_cur.rd_data = cur.debug_word;
            default: next_cur.rd_data = 24'h000000;
        endcase
    end

    // Reset restarts loading; erased defaults give the least protection
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur.state <= spc_st_load;
            cur.idx <= `SPC_IDX_BOOT;
            cur.got_idx <= `SPC_IDX_BOOT;
            cur.pending <= 1'b0;
            cur.boot_word <= `SPC_ERASED & `SPC_MASK_BOOT; // see [R17]
            cur.secure_word <= `SPC_ERASED & `SPC_MASK_SECURE;
            cur.general_word <= `SPC_ERASED & gen_mask; // Basic variant has no bit 2
            cur.debug_word <= `SPC_ERASED;
            cur.ram_limit_boot <= 1'b1;
            cur.ram_limit_secure <= 1'b1;
            cur.valid <= 1'b0;
            cur.rd_data <= 24'h000000;
        end else begin
            cur <= next_cur;
        end
    end

    assign cfg_rd_en = (cur.state == spc_st_load) && !reset;
    assign cfg_rd_idx = cur.idx;
    assign sw_rd_data = cur.rd_data;
    assign config_valid = cur.valid;

    spc_flash_decode u_boot_flash (
        .field(cur.boot_word[`SPC_FLASH_HI:`SPC_FLASH_LO]),
        .wrp(cur.boot_word[`SPC_WRP_BIT]),
        .seg(boot_seg)
    );

    spc_flash_decode u_secure_flash (
        .field(cur.secure_word[`SPC_FLASH_HI:`SPC_FLASH_LO]),
        .wrp(cur.secure_word[`SPC_WRP_BIT]),
        .seg(secure_seg)
    );

    spc_debug_decode u_debug (
        .word(cur.debug_word),
        .dbg(dbg_dec)
    );

    // Outputs decode only held words and latched limit bits, so they cannot move from end of loading to the next reset
    always_comb begin
        prot.boot_flash = boot_seg;
        prot.secure_flash = secure_seg;
        prot.general_write_ok = cur.general_word[`SPC_WRP_BIT]; // see [R12]
        if (ADVANCED) begin
            // see [R11]
            case (cur.general_word[`SPC_GSS_HI:`SPC_GSS_LO])
                2'h3: prot.general_sec = spc_sec_none;
                2'h2: prot.general_sec = spc_sec_standard;
                default: prot.general_sec = spc_sec_high;
            endcase
        end else begin
            // see [R13]
            prot.general_sec = cur.general_word[`SPC_GCP_BIT] ? spc_sec_none
                : spc_sec_standard;
        end
        case (cur.boot_word[`SPC_RAM_HI:`SPC_RAM_LO]) // see [R1]
            2'h3: prot.boot_ram_size = spc_size_none;
            2'h2: prot.boot_ram_size = spc_size_small;
            2'h1: prot.boot_ram_size = spc_size_medium;
            default: prot.boot_ram_size = spc_size_large;
        endcase
        // Secure RAM size is device specific; raw inputs passed on together
        prot.secure_ram_code = cur.secure_word[`SPC_RAM_HI:`SPC_RAM_LO]; // see [R7]
        prot.boot_ram_limit = cur.ram_limit_boot;
        prot.secure_ram_limit = cur.ram_limit_secure;
        // see [R2] see [R3]
        prot.boot_ee_bytes = cur.boot_word[`SPC_EE_BOOT_BIT] ? 16'h0000
            : `SPC_BOOT_EE_BYTES;
        // see [R8]
        case (cur.secure_word[`SPC_EE_SEC_HI:`SPC_EE_SEC_LO])
            2'h3: prot.secure_ee_bytes = 16'h0000;
            2'h0: prot.secure_ee_bytes = `SPC_SEC_EE_BYTES;
            default: prot.secure_ee_bytes = 16'h0000;
        endcase
        prot.secure_ee_reserved = (cur.secure_word[`SPC_EE_SEC_HI:`SPC_EE_SEC_LO] == 2'h1)
            || (cur.secure_word[`SPC_EE_SEC_HI:`SPC_EE_SEC_LO] == 2'h2);
        dbg = dbg_dec;
    end

    // Loader asks for each word once, in order, then goes quiet for good
    sequence read_walk_s;
        (cfg_rd_en && cfg_rd_idx == 3'h3) ##1 (cfg_rd_en && cfg_rd_idx == 3'h4)
        ##1 (cfg_rd_en && cfg_rd_idx == 3'h5) ##1 (cfg_rd_en && cfg_rd_idx == 3'h6);
    endsequence

    // Valid stays low while the four words and the limit bits settle
    sequence loading_s;
        !config_valid [*5];
    endsequence

    property valid_after_load_p;
        @(posedge mclk) disable iff (reset) $fell(reset) |-> loading_s ##1 config_valid;
    endproperty

    property read_order_p;
        @(posedge mclk) disable iff (reset) $fell(reset) |-> read_walk_s ##1 !cfg_rd_en;
    endproperty

    valid_timing_a: assert property (valid_after_load_p) // see [R18]
        else $error("config_valid not raised after loading");

    read_order_a: assert property (read_order_p) // see [R18]
        else $error("configuration words not read in order");

    read_quiet_a: assert property (@(posedge mclk) disable iff (reset) // see [R18]
        config_valid |-> !cfg_rd_en)
        else $error("configuration read after loading");

    outputs_stable_a: assert property (@(posedge mclk) disable iff (reset) // see [R18]
        config_valid && $past(config_valid) |-> $stable(prot) && $stable(dbg))
        else $error("decoded outputs changed after load");

    boot_mask_a: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        (cur.boot_word & ~`SPC_MASK_BOOT) == 24'h000000)
        else $error("boot word unimplemented bit set");

    secure_mask_a: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        (cur.secure_word & ~`SPC_MASK_SECURE) == 24'h000000)
        else $error("secure word unimplemented bit set");

    boot_ee_size_a: assert property (@(posedge mclk) disable iff (reset) // see [R2]
        prot.boot_ee_bytes == (cur.boot_word[8] ? 16'h0000 : 16'h0100))
        else $error("boot eeprom size wrong");

    secure_ee_a: assert property (@(posedge mclk) disable iff (reset) // see [R8]
        (cur.secure_word[9:8] == 2'h0) |-> prot.secure_ee_bytes == 16'h0800)
        else $error("secure eeprom size wrong");

    boot_wrp_a: assert property (@(posedge mclk) disable iff (reset) // see [R5]
        prot.boot_flash.write_ok == cur.boot_word[0])
        else $error("boot write permission wrong");

    secure_wrp_a: assert property (@(posedge mclk) disable iff (reset) // see [R10]
        prot.secure_flash.write_ok == cur.secure_word[0])
        else $error("secure write permission wrong");

    general_wrp_a: assert property (@(posedge mclk) disable iff (reset) // see [R12]
        prot.general_write_ok == cur.general_word[0])
        else $error("general write permission wrong");

    boot_none_a: assert property (@(posedge mclk) disable iff (reset) // see [R4]
        (cur.boot_word[2:1] == 2'h3) |-> prot.boot_flash.sec == spc_sec_none)
        else $error("boot flash none decode wrong");

    secure_high_a: assert property (@(posedge mclk) disable iff (reset) // see [R9]
        (cur.secure_word[3:1] == 3'h2) |-> prot.secure_flash.sec == spc_sec_high
        && prot.secure_flash.size == spc_size_small)
        else $error("secure flash decode wrong");

    debug_modes_a: assert property (@(posedge mclk) disable iff (reset) // see [R14]
        dbg.user_mode == cur.debug_word[7] && dbg.operational_mode == cur.debug_word[6])
        else $error("debug mode decode wrong");

    channel_shared_a: assert property (@(posedge mclk) disable iff (reset) // see [R16]
        (cur.debug_word[1:0] == 2'h3) |-> dbg.channel == spc_ch_shared)
        else $error("debug channel decode wrong");

    ram_none_a: assert property (@(posedge mclk) disable iff (reset) // see [R1]
        (cur.boot_word[13:12] == 2'h3) |-> prot.boot_ram_size == spc_size_none)
        else $error("boot ram decode wrong");

    // Fill of debug word unimplemented bits with ones
    debug_fill_a: assert property (@(posedge mclk) disable iff (reset) // see [R17]
        (cur.debug_word & `SPC_FILL_DEBUG) == `SPC_FILL_DEBUG)
        else $error("debug word fill wrong");

    // General word decode differs by variant; both share the write bit
    general_mask_a: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        (cur.general_word & ~gen_mask) == 24'h000000)
        else $error("general word unimplemented bit set");

    general_std_a: assert property (@(posedge mclk) disable iff (reset) // see [R11]
        ADVANCED && (cur.general_word[2:1] == 2'h2) |-> prot.general_sec == spc_sec_standard)
        else $error("general standard decode wrong");

    general_high_a: assert property (@(posedge mclk) disable iff (reset) // see [R11]
        ADVANCED && !cur.general_word[2] |-> prot.general_sec == spc_sec_high)
        else $error("general high decode wrong");

    general_basic_a: assert property (@(posedge mclk) disable iff (reset) // see [R13]
        !ADVANCED && !cur.general_word[1] |-> prot.general_sec == spc_sec_standard)
        else $error("general code protect decode wrong");

    general_open_a: assert property (@(posedge mclk) disable iff (reset) // see [R13]
        cur.general_word[1] && (cur.general_word[2] || !ADVANCED)
        |-> prot.general_sec == spc_sec_none)
        else $error("general unprotected decode wrong");

    // Code 11 must grant no EEPROM segment; reserved codes must raise the reserved flag
    secure_ee_none_a: assert property (@(posedge mclk) disable iff (reset) // see [R8]
        (cur.secure_word[9:8] == 2'h3) |-> prot.secure_ee_bytes == 16'h0000)
        else $error("secure eeprom none decode wrong");

    secure_reserved_a: assert property (@(posedge mclk) disable iff (reset) // see [R8]
        (cur.secure_word[9] != cur.secure_word[8]) |-> prot.secure_ee_reserved)
        else $error("secure eeprom reserved flag wrong");

    boot_small_a: assert property (@(posedge mclk) disable iff (reset) // see [R4]
        (cur.boot_word[3:1] == 3'h6) |-> prot.boot_flash.sec == spc_sec_standard
        && prot.boot_flash.size == spc_size_small)
        else $error("boot flash small decode wrong");

    ram_large_a: assert property (@(posedge mclk) disable iff (reset) // see [R1]
        (cur.boot_word[13:12] == 2'h0) |-> prot.boot_ram_size == spc_size_large)
        else $error("boot ram large decode wrong");

    channel_three_a: assert property (@(posedge mclk) disable iff (reset) // see [R16]
        (cur.debug_word[1:0] == 2'h0) |-> dbg.channel == spc_ch_three)
        else $error("debug channel three decode wrong");

    channel_one_a: assert property (@(posedge mclk) disable iff (reset) // see [R16]
        (cur.debug_word[1:0] == 2'h2) |-> dbg.channel == spc_ch_one)
        else $error("debug channel one decode wrong");

    // Limit bits are taken once, in the cycle before valid rises
    limit_latch_a: assert property (@(posedge mclk) disable iff (reset) // see [R7]
        $rose(config_valid) |-> prot.boot_ram_limit == $past(boot_ram_limit_bit)
        && prot.secure_ram_limit == $past(secure_ram_limit_bit))
        else $error("ram limit bits not latched");

    // Read-back lags the index by one cycle; reset clears it first
    readback_boot_a: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        !$past(reset) && $past(sw_rd_idx) == 3'h3 |-> sw_rd_data == $past(cur.boot_word))
        else $error("boot word read-back wrong");

    readback_fill_a: assert property (@(posedge mclk) disable iff (reset) // see [R17]
        !$past(reset) && $past(sw_rd_idx) == 3'h6
        |-> (sw_rd_data & `SPC_FILL_DEBUG) == `SPC_FILL_DEBUG)
        else $error("debug word read-back fill wrong");
endmodule
`default_nettype wire

// *** rtl/spc_debug_decode.sv ***
/*
 Decodes the debugger configuration word into start-up mode and channel.
 Assumes a held, settled configuration word at its input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module spc_debug_decode
    import spc_pkg::*;
(
    // Raw word
    input wire logic [23:0] word,
    // Decoded debug options
    output spc_debug_s dbg
);
    // Erased bits select user and operational mode on the shared pair
    always_comb begin
        dbg.user_mode = word[`SPC_BACKGROUND_DEBUG_SELECT_BIT]; // see [R14]
        dbg.operational_mode = word[`SPC_COE_BIT]; // see [R15]
        case (word[`SPC_ICS_HI:`SPC_ICS_LO]) // see [R16]
            2'h3: dbg.channel = spc_ch_shared;
            2'h2: dbg.channel = spc_ch_one;
            2'h1: dbg.channel = spc_ch_two;
            default: dbg.channel = spc_ch_three;
        endcase
    end
endmodule
`default_nettype wire

// *** rtl/spc_defines.svh ***
/*
 Offsets, field positions, masks and reset values for the segment
 protection configuration decoder. Assumes inclusion by bare name.
*/
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// Configuration word indices within configuration space
`define SPC_IDX_BOOT 3'h3
`define SPC_IDX_SECURE 3'h4
`define SPC_IDX_GENERAL 3'h5
`define SPC_IDX_DEBUG 3'h6
// Implemented-bit masks per word
`define SPC_MASK_BOOT 24'h00310F
`define SPC_MASK_SECURE 24'h00330F
`define SPC_MASK_GEN_ADV 24'h000007
`define SPC_MASK_GEN_BASIC 24'h000003
`define SPC_MASK_DEBUG 24'h0000C3
// Debugger word unimplemented bits read as one
`define SPC_FILL_DEBUG 24'hFFFF3C
// Field positions
`define SPC_RAM_HI 13
`define SPC_RAM_LO 12
`define SPC_EE_BOOT_BIT 8
`define SPC_EE_SEC_HI 9
`define SPC_EE_SEC_LO 8
`define SPC_FLASH_HI 3
`define SPC_FLASH_LO 1
`define SPC_WRP_BIT 0
`define SPC_GSS_HI 2
`define SPC_GSS_LO 1
`define SPC_GCP_BIT 1
`define SPC_BACKGROUND_DEBUG_SELECT_BIT 7
`define SPC_COE_BIT 6
`define SPC_ICS_HI 1
`define SPC_ICS_LO 0
// Sizes in bytes
`define SPC_BOOT_EE_BYTES 16'h0100
`define SPC_SEC_EE_BYTES 16'h0800
// Unprogrammed word value
`define SPC_ERASED 24'hFFFFFF
`define SPC_NUM_WORDS 3'h5

`endif

// *** rtl/spc_flash_decode.sv ***
/*
 Decodes one three-bit flash protection field plus its write-protect bit.
 Assumes a held, settled configuration word at its input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module spc_flash_decode
    import spc_pkg::*;
(
    // Raw fields
    input wire logic [2:0] field,
    input wire logic wrp,
    // Decoded segment
    output spc_flash_s seg
);
    // Low two bits give size, top bit security; x11 means no segment
    always_comb begin
        seg.write_ok = wrp; // see [R5] see [R10]
        case (field[1:0]) // see [R4] see [R9]
            2'h3: seg.size = spc_size_none;
            2'h2: seg.size = spc_size_small;
            2'h1: seg.size = spc_size_medium;
            default: seg.size = spc_size_large;
        endcase
        if (field[1:0] == 2'h3) begin
            seg.sec = spc_sec_none;
        end else if (field[2]) begin
            seg.sec = spc_sec_standard;
        end else begin
            seg.sec = spc_sec_high;
        end
    end
endmodule
`default_nettype wire

// *** rtl/spc_pkg.sv ***
/*
 Types of the segment protection configuration decoder.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spc_pkg;
    typedef enum logic [1:0] {spc_size_none, spc_size_small, spc_size_medium,
        spc_size_large} spc_size_e;
    typedef enum logic [1:0] {spc_sec_none, spc_sec_standard, spc_sec_high} spc_sec_e;
    typedef enum logic [2:0] {spc_ch_shared, spc_ch_one, spc_ch_two,
        spc_ch_three} spc_chan_e;
    typedef enum logic [1:0] {spc_st_load, spc_st_wait, spc_st_run} spc_state_e;

    // Decoded flash segment
    typedef struct packed {
        spc_size_e size;
        spc_sec_e sec;
        logic write_ok;
    } spc_flash_s;

    // All decoded protection outputs
    typedef struct packed {
        spc_flash_s boot_flash;
        spc_flash_s secure_flash;
        spc_sec_e general_sec;
        logic general_write_ok;
        spc_size_e boot_ram_size;
        logic [1:0] secure_ram_code;
        logic boot_ram_limit;
        logic secure_ram_limit;
        logic [15:0] boot_ee_bytes;
        logic [15:0] secure_ee_bytes;
        logic secure_ee_reserved;
    } spc_prot_s;

    // Debug start-up decode
    typedef struct packed {
        logic user_mode;
        logic operational_mode;
        spc_chan_e channel;
    } spc_debug_s;
endpackage

// *** verification/tb_top.sv ***
/*
 Self-checking bench for the configuration decoder, both general variants.
 Assumes the design package and defines header are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module tb_top
    import spc_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic lb = 1'b1;
    logic ls = 1'b1;
    logic olb;
    logic ols;
    logic [2:0] sw_idx = 3'h0;
    logic [23:0] mem [8];
    logic [23:0] w [8];
    logic en [2];
    logic [2:0] idx [2];
    logic [23:0] rdat [2] = '{24'h000000, 24'h000000};
    logic [23:0] swd [2];
    logic valid [2];
    spc_prot_s prot [2];
    spc_debug_s dbg [2];
    logic [11:0] seq [2];
    int mismatches = 0;
    int check_count = 0;

    // Instance 0 is the advanced variant, instance 1 the basic one
    for (genvar k = 0; k < 2; k++) begin : dut_g
        spc_config_decode #(.ADVANCED(k == 0)) spc_config_decode_i (
            .mclk(mclk), .reset(reset), .cfg_rd_en(en[k]), .cfg_rd_idx(idx[k]),
            .cfg_rd_data(rdat[k]), .boot_ram_limit_bit(lb),
            .secure_ram_limit_bit(ls), .sw_rd_idx(sw_idx), .sw_rd_data(swd[k]),
            .config_valid(valid[k]), .prot(prot[k]), .dbg(dbg[k]));
        // Memory answers a cycle later; idle data inverts so stale words never match
        always @(posedge mclk) begin
            rdat[k] <= #1 en[k] ? mem[idx[k]] : ~rdat[k];
            seq[k] <= reset ? 12'h000 : en[k] ? {seq[k][8:0], idx[k]} : seq[k];
        end
    end

    always #12.5 mclk = ~mclk;

    // Size codes count down from none to large
    function automatic spc_size_e sz(input logic [1:0] c);
        case (c)
            2'h3: return spc_size_none;
            2'h2: return spc_size_small;
            2'h1: return spc_size_medium;
            default: return spc_size_large;
        endcase
    endfunction

    function automatic spc_flash_s fl(input logic [3:0] f);
        fl.size = sz(f[2:1]);
        fl.sec = (f[2:1] == 2'h3) ? spc_sec_none : f[3] ? spc_sec_standard : spc_sec_high;
        fl.write_ok = f[0];
    endfunction

    function automatic spc_prot_s exp_prot(input logic adv);
        exp_prot.boot_flash = fl(w[3][3:0]);
        exp_prot.secure_flash = fl(w[4][3:0]);
        if (adv)
            exp_prot.general_sec = (w[5][2:1] == 2'h3) ? spc_sec_none :
                w[5][2] ? spc_sec_standard : spc_sec_high;
        else
            exp_prot.general_sec = w[5][1] ? spc_sec_none : spc_sec_standard;
        exp_prot.general_write_ok = w[5][0];
        exp_prot.boot_ram_size = sz(w[3][13:12]);
        exp_prot.secure_ram_code = w[4][13:12];
        exp_prot.boot_ram_limit = olb;
        exp_prot.secure_ram_limit = ols;
        exp_prot.boot_ee_bytes = w[3][8] ? 16'h0000 : 16'h0100;
        exp_prot.secure_ee_bytes = (w[4][9:8] == 2'h0) ? 16'h0800 : 16'h0000;
        exp_prot.secure_ee_reserved = w[4][9] ^ w[4][8];
    endfunction

    function automatic spc_debug_s exp_dbg();
        exp_dbg.user_mode = w[6][7];
        exp_dbg.operational_mode = w[6][6];
        case (w[6][1:0])
            2'h3: exp_dbg.channel = spc_ch_shared;
            2'h2: exp_dbg.channel = spc_ch_one;
            2'h1: exp_dbg.channel = spc_ch_two;
            default: exp_dbg.channel = spc_ch_three;
        endcase
    endfunction

    // Held words as software sees them
    function automatic logic [23:0] exp_sw(input logic [2:0] i, input logic adv);
        case (i)
            3'h3: return w[3] & `SPC_MASK_BOOT;
            3'h4: return w[4] & `SPC_MASK_SECURE;
            3'h5: return w[5] & (adv ? `SPC_MASK_GEN_ADV : `SPC_MASK_GEN_BASIC);
            3'h6: return (w[6] & `SPC_MASK_DEBUG) | `SPC_FILL_DEBUG;
            default: return 24'h000000;
        endcase
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_out();
        for (int k = 0; k < 2; k++) begin
            check(64'(prot[k]), 64'(exp_prot(k == 0)));
            check(64'(prot[k]), 64'(exp_prot(k == 0)));
            check(64'(dbg[k]), 64'(exp_dbg()));
            check(64'(valid[k]), 64'h1);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond 32 rounds of about 20 cycles
    initial begin
        #(25 * 6000);
        mismatches++;
        finish_test();
    end

    initial begin
        int n;
        void'($urandom(42));
        repeat (6) @(posedge mclk);
        #1;
        for (int r = 0; r < 32; r++) begin
            // First rounds sweep every field code, then full-word corners and random
            for (int i = 0; i < 8; i++) begin
                mem[i] = 24'($urandom);
                if (r < 16)
                    mem[i][15:0] = {4{r[3:0]}};
                if (r == 16)
                    mem[i] = 24'h000000;
                if (r == 17)
                    mem[i] = `SPC_ERASED;
                w[i] = mem[i];
            end
            olb = 1'($urandom);
            ols = 1'($urandom);
            lb = olb;
            ls = ols;
            repeat (2) @(posedge mclk);
            #1 reset = 1'b0;
            n = 0;
            while (valid[0] !== 1'b1 && n < 20) begin
                @(posedge mclk);
                #1 n++;
            end
            check(64'(n >= 5 && n <= 7), 64'h1);
            check(64'(seq[0]), 64'h72E);
            check(64'(seq[1]), 64'h72E);
            chk_out();
            // Later changes in memory and limit bits must not reach the outputs
            for (int i = 0; i < 8; i++)
                mem[i] = 24'($urandom);
            lb = ~olb;
            ls = ~ols;
            repeat (3) @(posedge mclk);
            #1 chk_out();
            for (int i = 0; i < 8; i++) begin
                sw_idx = 3'(i);
                @(posedge mclk);
                #1 check(64'(swd[0]), 64'(exp_sw(3'(i), 1'b1)));
                check(64'(swd[1]), 64'(exp_sw(3'(i), 1'b0)));
            end
            reset = 1'b1;
            $display("test %0d done", r);
        end
        finish_test();
    end
endmodule
`default_nettype wire
